/* verilog/irq_unit_pkg.sv */
package irq_unit_pkg;
	// event sources, in fixed arbitration order (rank 2 upward)
	localparam int NUM_SRC = 17;
	localparam int NUM_EXC = 5;
	localparam int NUM_PRIO_REG = 9;
	localparam int PRIO_W = 3;
	localparam int LEVEL_W = 4;
	localparam int VEC_W = 16;

	// register byte offsets on the bus
	localparam logic [7:0] OFS_ENABLE_LOW = 8'h00;
	localparam logic [7:0] OFS_ENABLE_HIGH = 8'h04;
	localparam logic [7:0] OFS_RESET_CAUSE = 8'h08;
	localparam logic [7:0] OFS_POWER_CTRL = 8'h0c;
	localparam logic [7:0] OFS_PRIO_BASE = 8'h10;
	localparam logic [7:0] OFS_PERIPH_KEEP = 8'h34;
	localparam logic [7:0] OFS_STATUS = 8'h38;
	localparam logic [7:0] OFS_STATUS_CLR = 8'h3c;
	localparam logic [7:0] OFS_IRQ_ENABLE = 8'h40;

	// field layouts
	localparam int GLOBAL_GATE_BIT = 7;
	localparam int LOW_EN_COUNT = 7;
	localparam int HIGH_EN_COUNT = 10;
	localparam int PRIO_HI_LSB = 4;
	localparam int CAUSE_PIN_BIT = 0;
	localparam int CAUSE_CMD_BIT = 1;
	localparam int CAUSE_WD_BIT = 2;
	localparam int CAUSE_W = 3;
	localparam int PWR_IDLE_BIT = 0;
	localparam int PWR_DOWN_BIT = 1;
	localparam int ST_PD_WAKE = 0;
	localparam int ST_IDLE_WAKE = 1;
	localparam int ST_EXC_TAKEN = 2;
	localparam int ST_W = 3;
	localparam int SRC_EXT_ZERO = 0;
	localparam int SRC_EXT_ONE = 2;
	localparam int SRC_FIRST_SERIAL = 7;
	localparam int SRC_FIRST_CHANNEL = 11;
	localparam int SRC_NO_HALF = 7;

	// vector table
	localparam logic [15:0] VEC_EXC_BASE = 16'h0004;
	localparam logic [15:0] VEC_TRAP_BASE = 16'h0040;
	localparam logic [15:0] VEC_EVT_BASE = 16'h0080;
	localparam logic [15:0] VEC_SERIAL_BASE = 16'h00a0;
	localparam logic [15:0] VEC_CHANNEL_BASE = 16'h00c0;
	localparam logic [3:0] EVT_LEVEL_TOP = 4'h8;
	localparam logic [3:0] EXC_LEVEL = 4'hf;

	// reset values
	localparam logic [31:0] RST_ZERO = 32'h0000_0000;
	localparam logic [16:0] RST_KEEP = 17'h1_ffff;

	// core power state, gray along run -> idle -> down
	typedef enum logic [1:0] {
		PWR_RUN = 2'b00,
		PWR_IDLE = 2'b01,
		PWR_DOWN = 2'b11
	} pwr_state_t;
endpackage

/* verilog/event_interrupt_priority_unit.sv */
`timescale 1ns/1ps
// Summary of operation
// - idle keeps selected peripheral clocks running
// - power-down stops oscillator, state kept
// - power-down exits only by reset, ext pins
// - pin wakes if enabled and above mask
// - cause bits: 2 watchdog, 1 command, 0 pin
// - 17 events, 5 exceptions, 16 traps
// - events gated by global and own enable
// - three-bit priority field per event
// - zero disables, n maps to 8 plus n
// - equal priority served lowest rank first
// - exception and trap vector addresses
// - event vectors from 0080, ranks 2-8
// - serial port vectors from 00a0
// - channel vectors 00c0, two-wire at 00d4
// - two fields per priority register except A3, which holds one, in order
// - cause register shows latest reset only
module event_interrupt_priority_unit (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	input wire logic [16:0] evt_flag_i,
	input wire logic ext_irq_in_zero_i,
	input wire logic ext_irq_in_one_i,
	input wire logic [4:0] exc_req_i,
	input wire logic trap_req_i,
	input wire logic [3:0] trap_num_i,
	input wire logic [3:0] exec_level_i,
	input wire logic core_ack_i,
	input wire logic cause_pin_i,
	input wire logic cause_cmd_i,
	input wire logic cause_watchdog_i,
	output logic req_valid_o,
	output logic [15:0] vector_o,
	output logic [3:0] req_level_o,
	output logic core_clk_en_o,
	output logic osc_en_o,
	output logic [16:0] periph_clk_en_o,
	output logic irq_o
);

	////////////////////////////////////////////////////////////////////
	// helpers

	// which priority register holds a source (A0-A5 = 0-5, B0-B2 = 6-8)
	function automatic logic [3:0] src_reg(input int i);
		int r;
		r = (i < 6) ? i / 2 : (i == 6) ? 3 : (i + 1) / 2;
		return 4'(r);
	endfunction

	// field half inside that register: 0 = bits 2-0, 1 = bits 6-4
	function automatic logic src_half(input int i);
		return (i < irq_unit_pkg::SRC_NO_HALF) ? 1'(i % 2) : 1'((i + 1) % 2);
	endfunction

	// effective level: zero stays zero, n becomes 8 + n
	function automatic logic [3:0] eff_level(input logic [2:0] p);
		return (p == 3'h0) ? 4'h0 : (irq_unit_pkg::EVT_LEVEL_TOP | {1'b0, p});
	endfunction

	// vector of event source i
	function automatic logic [15:0] evt_vector(input int i);
		logic [15:0] v;
		if (i < irq_unit_pkg::SRC_FIRST_SERIAL)
			v = irq_unit_pkg::VEC_EVT_BASE + 16'(4 * i);
		else if (i < irq_unit_pkg::SRC_FIRST_CHANNEL)
			v = irq_unit_pkg::VEC_SERIAL_BASE
				+ 16'(4 * (i - irq_unit_pkg::SRC_FIRST_SERIAL));
		else
			v = irq_unit_pkg::VEC_CHANNEL_BASE
				+ 16'(4 * (i - irq_unit_pkg::SRC_FIRST_CHANNEL));
		return v;
	endfunction

	// bus address to priority register number, 15 when not one
	function automatic logic [3:0] prio_slot(input logic [7:0] a);
		logic [3:0] s;
		s = 4'hf;
		for (int r = 0; r < irq_unit_pkg::NUM_PRIO_REG; r++)
			if (a == irq_unit_pkg::OFS_PRIO_BASE + 8'(4 * r))
				s = 4'(r);
		return s;
	endfunction

	////////////////////////////////////////////////////////////////////
	// state

	logic [7:0] en_low_ff;
	logic [9:0] en_high_ff;
	logic [2:0] prio_ff [0:16];
	logic [2:0] cause_ff;
	logic [16:0] keep_ff;
	logic [2:0] status_ff;
	logic [2:0] irq_en_ff;
	irq_unit_pkg::pwr_state_t mode_ff;
	logic [1:0] ext0_sync_ff;
	logic [1:0] ext1_sync_ff;
	logic [16:0] enables;
	logic gate;
	logic bus_req;
	logic wr_en;
	logic [3:0] slot;
	logic [31:0] rd_data;
	logic [16:0] pend;
	logic found;
	logic [4:0] best_idx;
	logic [3:0] best_lvl;
	logic exc_any;
	logic [15:0] exc_vec;
	logic take;
	logic [15:0] take_vec;
	logic [3:0] take_lvl;
	logic pd_wake;
	logic [2:0] status_set;
	logic [2:0] status_clr;

	assign enables = {en_high_ff, en_low_ff[irq_unit_pkg::LOW_EN_COUNT-1:0]};
	assign gate = en_low_ff[irq_unit_pkg::GLOBAL_GATE_BIT];
	assign bus_req = cyc_i && stb_i && !ack_o;
	assign wr_en = bus_req && we_i;
	assign slot = prio_slot(adr_i);

	////////////////////////////////////////////////////////////////////
	// register bus: one wait state, every address answered

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			ack_o <= 1'b0;
		else
			ack_o <= bus_req;
	end

	// read mux, unmapped and write-only offsets read zero
	always_comb
	begin
		rd_data = irq_unit_pkg::RST_ZERO;
		case (adr_i)
			irq_unit_pkg::OFS_ENABLE_LOW: rd_data[7:0] = en_low_ff;
			irq_unit_pkg::OFS_ENABLE_HIGH: rd_data[9:0] = en_high_ff;
			irq_unit_pkg::OFS_RESET_CAUSE: rd_data[2:0] = cause_ff;
			irq_unit_pkg::OFS_POWER_CTRL: rd_data[1:0] = mode_ff;
			irq_unit_pkg::OFS_PERIPH_KEEP: rd_data[16:0] = keep_ff;
			irq_unit_pkg::OFS_STATUS: rd_data[2:0] = status_ff;
			irq_unit_pkg::OFS_IRQ_ENABLE: rd_data[2:0] = irq_en_ff;
			default: rd_data = irq_unit_pkg::RST_ZERO;
		endcase
		for (int i = 0; i < irq_unit_pkg::NUM_SRC; i++)
			if (slot != 4'hf && src_reg(i) == slot)
			begin
				if (src_half(i))
					rd_data[irq_unit_pkg::PRIO_HI_LSB +: 3] = prio_ff[i];
				else
					rd_data[2:0] = prio_ff[i];
			end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			dat_o <= irq_unit_pkg::RST_ZERO;
		else if (bus_req && !we_i)
			dat_o <= rd_data;
	end

	// enable registers, low byte lane only for the gate byte
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			en_low_ff <= '0;
			en_high_ff <= '0;
			keep_ff <= irq_unit_pkg::RST_KEEP;
			irq_en_ff <= '0;
		end
		else if (wr_en)
		begin
			if (adr_i == irq_unit_pkg::OFS_ENABLE_LOW && sel_i[0])
				en_low_ff <= dat_i[7:0];
			if (adr_i == irq_unit_pkg::OFS_ENABLE_HIGH)
			begin
				if (sel_i[0])
					en_high_ff[7:0] <= dat_i[7:0];
				if (sel_i[1])
					en_high_ff[9:8] <= dat_i[9:8];
			end
			if (adr_i == irq_unit_pkg::OFS_PERIPH_KEEP)
			begin
				if (sel_i[0])
					keep_ff[7:0] <= dat_i[7:0];
				if (sel_i[1])
					keep_ff[15:8] <= dat_i[15:8];
				if (sel_i[2])
					keep_ff[16] <= dat_i[16];
			end
			if (adr_i == irq_unit_pkg::OFS_IRQ_ENABLE && sel_i[0])
				irq_en_ff <= dat_i[2:0];
		end
	end

	// priority fields; the fourth bit of each nibble is not stored
	// three-bit fields
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			for (int i = 0; i < irq_unit_pkg::NUM_SRC; i++)
				prio_ff[i] <= 3'h0;
		end
		else if (wr_en && slot != 4'hf && sel_i[0])
		begin
			for (int i = 0; i < irq_unit_pkg::NUM_SRC; i++)
				if (src_reg(i) == slot)
					prio_ff[i] <= src_half(i)
						? dat_i[irq_unit_pkg::PRIO_HI_LSB +: 3] : dat_i[2:0];
		end
	end

	////////////////////////////////////////////////////////////////////
	// reset cause: read-only, written only while reset is applied

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			cause_ff[irq_unit_pkg::CAUSE_WD_BIT] <= cause_watchdog_i;
			cause_ff[irq_unit_pkg::CAUSE_CMD_BIT] <= cause_cmd_i;
			cause_ff[irq_unit_pkg::CAUSE_PIN_BIT] <= cause_pin_i;
		end
	end

	////////////////////////////////////////////////////////////////////
	// arbitration

	assign pend = evt_flag_i & enables & {irq_unit_pkg::NUM_SRC{gate}};

	// scan downward so an equal level at a lower rank replaces it
	// lowest rank wins among equal levels
	always_comb
	begin
		found = 1'b0;
		best_idx = 5'h0;
		best_lvl = 4'h0;
		for (int i = irq_unit_pkg::NUM_SRC - 1; i >= 0; i--)
			if (pend[i] && eff_level(prio_ff[i]) != 4'h0
				&& eff_level(prio_ff[i]) >= best_lvl)
			begin
				found = 1'b1;
				best_idx = 5'(i);
				best_lvl = eff_level(prio_ff[i]);
			end
	end

	// exceptions rank ahead of all events, lowest slot first
	// exception vectors
	always_comb
	begin
		exc_vec = irq_unit_pkg::VEC_TRAP_BASE + {10'h0, trap_num_i, 2'h0};
		for (int e = irq_unit_pkg::NUM_EXC - 1; e >= 0; e--)
			if (exc_req_i[e])
				exc_vec = irq_unit_pkg::VEC_EXC_BASE + 16'(4 * e);
	end
	assign exc_any = (|exc_req_i) || trap_req_i;

	always_comb
	begin
		take = 1'b0;
		take_vec = exc_vec;
		take_lvl = irq_unit_pkg::EXC_LEVEL;
		if (mode_ff != irq_unit_pkg::PWR_DOWN)
		begin
			if (exc_any)
				take = 1'b1;
			else if (found && best_lvl > exec_level_i)
			begin
				take = 1'b1;
				take_vec = evt_vector(int'(best_idx));
				take_lvl = best_lvl;
			end
		end
	end

	// request held until the core acknowledges it
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			req_valid_o <= 1'b0;
			vector_o <= '0;
			req_level_o <= '0;
		end
		else if (!req_valid_o || core_ack_i)
		begin
			req_valid_o <= take;
			vector_o <= take_vec;
			req_level_o <= take_lvl;
		end
	end

	////////////////////////////////////////////////////////////////////
	// power modes

	// wake pins arrive asynchronously while the core sleeps
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ext0_sync_ff <= 2'b00;
			ext1_sync_ff <= 2'b00;
		end
		else
		begin
			ext0_sync_ff <= {ext0_sync_ff[0], ext_irq_in_zero_i};
			ext1_sync_ff <= {ext1_sync_ff[0], ext_irq_in_one_i};
		end
	end

	assign pd_wake = gate && (
		(ext0_sync_ff[1] && enables[irq_unit_pkg::SRC_EXT_ZERO]
			&& eff_level(prio_ff[irq_unit_pkg::SRC_EXT_ZERO]) > exec_level_i)
		|| (ext1_sync_ff[1] && enables[irq_unit_pkg::SRC_EXT_ONE]
			&& eff_level(prio_ff[irq_unit_pkg::SRC_EXT_ONE]) > exec_level_i));

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			mode_ff <= irq_unit_pkg::PWR_RUN;
		else
			case (mode_ff)
				irq_unit_pkg::PWR_RUN:
					if (wr_en && adr_i == irq_unit_pkg::OFS_POWER_CTRL && sel_i[0])
					begin
						if (dat_i[irq_unit_pkg::PWR_DOWN_BIT])
							mode_ff <= irq_unit_pkg::PWR_DOWN;
						else if (dat_i[irq_unit_pkg::PWR_IDLE_BIT])
							mode_ff <= irq_unit_pkg::PWR_IDLE;
					end
				// any request that would be taken reactivates the core
				irq_unit_pkg::PWR_IDLE:
					if (take)
						mode_ff <= irq_unit_pkg::PWR_RUN;
				irq_unit_pkg::PWR_DOWN:
					if (pd_wake)
						mode_ff <= irq_unit_pkg::PWR_RUN;
				default: mode_ff <= irq_unit_pkg::PWR_RUN;
			endcase
	end

	// clock gates follow the state; registers are never reset by sleep
	// idle keep mask
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			core_clk_en_o <= 1'b1;
			osc_en_o <= 1'b1;
			periph_clk_en_o <= irq_unit_pkg::RST_KEEP;
		end
		else
		begin
			core_clk_en_o <= (mode_ff == irq_unit_pkg::PWR_RUN);
			osc_en_o <= (mode_ff != irq_unit_pkg::PWR_DOWN);
			case (mode_ff)
				irq_unit_pkg::PWR_IDLE: periph_clk_en_o <= keep_ff;
				irq_unit_pkg::PWR_DOWN: periph_clk_en_o <= '0;
				default: periph_clk_en_o <= irq_unit_pkg::RST_KEEP;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// interrupt status: set beats clear in the same cycle

	assign status_set[irq_unit_pkg::ST_PD_WAKE] =
		(mode_ff == irq_unit_pkg::PWR_DOWN) && pd_wake;
	assign status_set[irq_unit_pkg::ST_IDLE_WAKE] =
		(mode_ff == irq_unit_pkg::PWR_IDLE) && take;
	assign status_set[irq_unit_pkg::ST_EXC_TAKEN] =
		(!req_valid_o || core_ack_i) && take && exc_any;
	assign status_clr = (wr_en && adr_i == irq_unit_pkg::OFS_STATUS_CLR
		&& sel_i[0]) ? dat_i[2:0] : 3'h0;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			status_ff <= '0;
		else
			status_ff <= (status_ff & ~status_clr) | status_set;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			irq_o <= 1'b0;
		else
			irq_o <= |(status_ff & irq_en_ff);
	end

	////////////////////////////////////////////////////////////////////
	// checks

	chk_cause_capture: assert property (@(posedge clk_i)
		rst_i |=> cause_ff == $past({cause_watchdog_i, cause_cmd_i,
			cause_pin_i}))
		else $error("reset cause not rewritten");

	chk_cause_hold: assert property (@(posedge clk_i)
		disable iff (rst_i) !rst_i |=> $stable(cause_ff))
		else $error("reset cause changed outside reset");

	chk_osc_stop: assert property (@(posedge clk_i)
		disable iff (rst_i)
		mode_ff == irq_unit_pkg::PWR_DOWN |=> !osc_en_o && !core_clk_en_o)
		else $error("oscillator runs in power-down");

	chk_down_stays: assert property (@(posedge clk_i)
		disable iff (rst_i)
		(mode_ff == irq_unit_pkg::PWR_DOWN && !pd_wake)
			|=> mode_ff == irq_unit_pkg::PWR_DOWN)
		else $error("power-down left without a wake pin");

	chk_pin_wake: assert property (@(posedge clk_i)
		disable iff (rst_i)
		(mode_ff == irq_unit_pkg::PWR_DOWN && pd_wake)
			|=> mode_ff == irq_unit_pkg::PWR_RUN ##1 osc_en_o)
		else $error("enabled pin did not wake");

	chk_idle_clocks: assert property (@(posedge clk_i)
		disable iff (rst_i)
		mode_ff == irq_unit_pkg::PWR_IDLE |=> periph_clk_en_o == $past(keep_ff))
		else $error("idle peripheral clocks wrong");

	chk_event_level: assert property (@(posedge clk_i)
		disable iff (rst_i)
		(req_valid_o && vector_o >= irq_unit_pkg::VEC_EVT_BASE)
			|-> req_level_o > irq_unit_pkg::EVT_LEVEL_TOP)
		else $error("event level below nine");

	chk_gate_exec: assert property (@(posedge clk_i)
		disable iff (rst_i)
		($rose(req_valid_o) && vector_o >= irq_unit_pkg::VEC_EVT_BASE)
			|-> $past(gate) && req_level_o > $past(exec_level_i))
		else $error("event taken while gated or masked");

	chk_exc_first: assert property (@(posedge clk_i)
		disable iff (rst_i)
		(!req_valid_o && exc_any && mode_ff != irq_unit_pkg::PWR_DOWN)
			|=> req_valid_o && vector_o < irq_unit_pkg::VEC_EVT_BASE)
		else $error("exception not presented first");

	chk_bus_ack: assert property (@(posedge clk_i)
		disable iff (rst_i)
		(cyc_i && stb_i && !ack_o) |=> ack_o ##1 !ack_o)
		else $error("bus ack not a single cycle");

endmodule

/* testbench/evt_core_model.sv */
`timescale 1ns/1ps
module evt_core_model (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic slow_i,
	input wire logic [16:0] set_i,
	input wire logic req_valid_i,
	input wire logic [15:0] vector_i,
	input wire logic [3:0] level_i,
	output logic [16:0] flag_o,
	output logic ack_o,
	output logic [15:0] vec_o,
	output logic [3:0] lvl_o,
	output logic [7:0] cnt_o
);
	logic [1:0] wait_ff;
	logic [1:0] nxt_wait;

	// map a taken vector back to the event flag it serves
	function automatic logic [16:0] clr_mask(input logic [15:0] v);
		if (v >= 16'h0080 && v < 16'h009c)
			return 17'h1 << ((v - 16'h0080) >> 2);
		if (v >= 16'h00a0 && v < 16'h00b0)
			return 17'h1 << (((v - 16'h00a0) >> 2) + 16'h7);
		if (v >= 16'h00c0 && v < 16'h00d8)
			return 17'h1 << (((v - 16'h00c0) >> 2) + 16'hb);
		return 17'h0;
	endfunction

	assign nxt_wait = wait_ff + 2'h1;

	// core takes a vector at once or after three cycles; the peripheral
	// drops its flag as the vector is taken, so nothing is re-presented
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			flag_o <= 17'h0;
			ack_o <= 1'b0;
			wait_ff <= 2'h0;
			vec_o <= 16'h0;
			lvl_o <= 4'h0;
			cnt_o <= 8'h0;
		end
		else if (req_valid_i && !ack_o && (!slow_i || wait_ff == 2'h3))
		begin
			ack_o <= 1'b1;
			wait_ff <= 2'h0;
			vec_o <= vector_i;
			lvl_o <= level_i;
			cnt_o <= cnt_o + 8'h1;
			flag_o <= (flag_o | set_i) & ~clr_mask(vector_i);
		end
		else
		begin
			ack_o <= 1'b0;
			flag_o <= flag_o | set_i;
			if (req_valid_i && !ack_o)
				wait_ff <= nxt_wait;
		end
	end
endmodule

/* testbench/event_interrupt_priority_unit_tb_top.sv */
`timescale 1ns/1ps
module event_interrupt_priority_unit_tb_top;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
	logic [7:0] adr_i = 8'h0;
	logic [3:0] sel_i = 4'h0;
	logic [31:0] dat_i = 32'h0;
	logic [16:0] set_evt = 17'h0;
	logic slow = 1'b0, trap = 1'b0, pin0 = 1'b0, pin1 = 1'b0;
	logic [4:0] exc = 5'h0;
	logic [3:0] trap_num = 4'h0, exec = 4'h0;
	logic [2:0] cause = 3'h1;
	logic [31:0] dat_o;
	logic ack_o, req_valid_o, core_clk_en_o, osc_en_o, irq_o, core_ack;
	logic [15:0] vector_o, tvec;
	logic [3:0] req_level_o, tlvl;
	logic [16:0] periph_clk_en_o, flags;
	logic [7:0] tcnt, base;
	int miscompares = 0;
	int checks_done = 0;

	always #2 clk_i = ~clk_i;

	// the core withdraws an exception in the cycle it takes it
	event_interrupt_priority_unit i_dut (.clk_i(clk_i), .rst_i(rst_i),
		.cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
		.sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
		.evt_flag_i(flags), .ext_irq_in_zero_i(pin0),
		.ext_irq_in_one_i(pin1), .exc_req_i(core_ack ? 5'h0 : exc),
		.trap_req_i(trap & !core_ack), .trap_num_i(trap_num),
		.exec_level_i(exec), .core_ack_i(core_ack),
		.cause_pin_i(cause[0]), .cause_cmd_i(cause[1]),
		.cause_watchdog_i(cause[2]), .req_valid_o(req_valid_o),
		.vector_o(vector_o), .req_level_o(req_level_o),
		.core_clk_en_o(core_clk_en_o), .osc_en_o(osc_en_o),
		.periph_clk_en_o(periph_clk_en_o), .irq_o(irq_o));

	evt_core_model i_model (.clk_i(clk_i), .rst_i(rst_i), .slow_i(slow),
		.set_i(set_evt), .req_valid_i(req_valid_o), .vector_i(vector_o),
		.level_i(req_level_o), .flag_o(flags), .ack_o(core_ack),
		.vec_o(tvec), .lvl_o(tlvl), .cnt_o(tcnt));

	////////////////////////////////////////////////////////////////////
	task stop_test;
		$display("miscompares=%0d checks_done=%0d", miscompares, checks_done);
		if (miscompares == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			miscompares++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task tick(input int n);
		repeat (n) @(posedge clk_i);
	endtask

	// one classic cycle, held until ack is sampled, then a gap cycle
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int k;
		k = 0;
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		sel_i <= 4'hf;
		dat_i <= d;
		do
		begin
			@(posedge clk_i);
			k++;
		end
		while (ack_o !== 1'b1 && k < 50);
		q = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i <= 1'b0;
		if (k >= 50)
		begin
			miscompares++;
			stop_test;
		end
		tick(1);
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		wb(1'b1, a, d, q);
	endtask

	task rd_chk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		wb(1'b0, a, 32'h0, q);
		chk(q, exp);
	endtask

	task do_reset(input logic [2:0] c);
		cause <= c;
		rst_i <= 1'b1;
		tick(4);
		rst_i <= 1'b0;
		cause <= 3'h0;
		tick(1);
	endtask

	// field layout: A0..A3 hold sources 0-6, A4 onward sources 7-16
	task prio(input int s, input logic [2:0] n);
		int r;
		logic hi;
		r = s < 7 ? s / 2 : 4 + (s - 7) / 2;
		hi = s < 7 ? (s % 2 == 1) : ((s - 7) % 2 == 1);
		wr(irq_unit_pkg::OFS_PRIO_BASE + 8'(4 * r),
			hi ? {25'h0, n, 4'h0} : {29'h0, n});
	endtask

	task raise(input logic [16:0] m);
		base = tcnt;
		set_evt <= m;
		tick(1);
		set_evt <= 17'h0;
	endtask

	task expect_take(input logic [15:0] v, input logic [3:0] l);
		int k;
		k = 0;
		while (tcnt == base && k < 80)
		begin
			@(posedge clk_i);
			k++;
		end
		if (k >= 80)
		begin
			miscompares++;
			stop_test;
		end
		chk(32'(tvec), 32'(v));
		chk(32'(tlvl), 32'(l));
		base = tcnt;
	endtask

	function automatic logic [15:0] vec_of(input int s);
		if (s < 7)
			return 16'h0080 + 16'(4 * s);
		if (s < 11)
			return 16'h00a0 + 16'(4 * (s - 7));
		return 16'h00c0 + 16'(4 * (s - 11));
	endfunction

	////////////////////////////////////////////////////////////////////
	task t_reset_vals;
		rd_chk(irq_unit_pkg::OFS_RESET_CAUSE, 32'h1);
		rd_chk(irq_unit_pkg::OFS_POWER_CTRL, 32'h0);
		rd_chk(irq_unit_pkg::OFS_PERIPH_KEEP, 32'h1ffff);
		rd_chk(8'hfc, 32'h0);
		chk(32'(irq_o), 32'h0);
	endtask

	task t_cause;
		for (int k = 0; k < 3; k++)
		begin
			do_reset(3'(1 << k));
			wr(irq_unit_pkg::OFS_RESET_CAUSE, 32'h0);
			rd_chk(irq_unit_pkg::OFS_RESET_CAUSE, 32'(1 << k));
		end
	endtask

	// every source once, levels 1..7 mapped to 9..15
	task t_vectors;
		wr(irq_unit_pkg::OFS_ENABLE_LOW, 32'hff);
		wr(irq_unit_pkg::OFS_ENABLE_HIGH, 32'h3ff);
		for (int s = 0; s < 17; s++)
		begin
			prio(s, 3'(s % 7 + 1));
			raise(17'h1 << s);
			expect_take(vec_of(s), 4'(9 + s % 7));
		end
	endtask

	// one pending flag blocked by each gate in turn
	task t_gating;
		prio(3, 3'h0);
		raise(17'h8);
		tick(20);
		chk(32'(tcnt), 32'(base));
		// gate off first, or the flag is taken as soon as its level lands
		wr(irq_unit_pkg::OFS_ENABLE_LOW, 32'h08);
		prio(3, 3'h2);
		tick(20);
		chk(32'(tcnt), 32'(base));
		wr(irq_unit_pkg::OFS_ENABLE_LOW, 32'h80);
		tick(20);
		chk(32'(tcnt), 32'(base));
		exec <= 4'ha;
		wr(irq_unit_pkg::OFS_ENABLE_LOW, 32'h88);
		tick(20);
		chk(32'(tcnt), 32'(base));
		exec <= 4'h9;
		expect_take(16'h008c, 4'ha);
		exec <= 4'h0;
	endtask

	task t_ties;
		slow <= 1'b1;
		prio(9, 3'h3);
		prio(12, 3'h3);
		raise(17'h1200);
		expect_take(16'h00a8, 4'hb);
		expect_take(16'h00c4, 4'hb);
		prio(12, 3'h5);
		raise(17'h1200);
		expect_take(16'h00c4, 4'hd);
		expect_take(16'h00a8, 4'hb);
		slow <= 1'b0;
	endtask

	task t_exc;
		exec <= 4'hf;
		for (int i = 0; i < 5; i++)
		begin
			exc <= 5'(1 << i);
			expect_take(16'h0004 + 16'(4 * i), 4'hf);
		end
		exc <= 5'h0;
		trap <= 1'b1;
		trap_num <= 4'hf;
		expect_take(16'h007c, 4'hf);
		trap <= 1'b0;
		exec <= 4'h0;
		// source 1 needs its own enable next to the gate
		wr(irq_unit_pkg::OFS_ENABLE_LOW, 32'h82);
		prio(1, 3'h7);
		exc <= 5'h04;
		raise(17'h2);
		expect_take(16'h000c, 4'hf);
		exc <= 5'h0;
		expect_take(16'h0084, 4'hf);
		rd_chk(irq_unit_pkg::OFS_STATUS, 32'h4);
	endtask

	// wake from power-down only through an enabled pin above the mask
	task t_power;
		int k;
		// exception status from earlier scenarios would show beside the wake bit in the status read
		wr(irq_unit_pkg::OFS_STATUS_CLR, 32'h7);
		wr(irq_unit_pkg::OFS_ENABLE_LOW, 32'h80);
		prio(0, 3'h2);
		wr(irq_unit_pkg::OFS_POWER_CTRL, 32'h2);
		tick(3);
		chk(32'(osc_en_o), 32'h0);
		chk(32'(periph_clk_en_o), 32'h0);
		rd_chk(irq_unit_pkg::OFS_POWER_CTRL, 32'h3);
		pin0 <= 1'b1;
		tick(10);
		chk(32'(osc_en_o), 32'h0);
		exec <= 4'ha;
		wr(irq_unit_pkg::OFS_ENABLE_LOW, 32'h81);
		tick(10);
		chk(32'(osc_en_o), 32'h0);
		exec <= 4'h9;
		k = 0;
		while (osc_en_o !== 1'b1 && k < 20)
		begin
			@(posedge clk_i);
			k++;
		end
		chk(32'(k < 20), 32'h1);
		if (k >= 20)
			stop_test;
		exec <= 4'h0;
		pin0 <= 1'b0;
		rd_chk(irq_unit_pkg::OFS_ENABLE_LOW, 32'h81);
		rd_chk(irq_unit_pkg::OFS_STATUS, 32'h1);
		chk(32'(irq_o), 32'h0);
		wr(irq_unit_pkg::OFS_IRQ_ENABLE, 32'h1);
		tick(2);
		chk(32'(irq_o), 32'h1);
		wr(irq_unit_pkg::OFS_STATUS_CLR, 32'h7);
		tick(2);
		chk(32'(irq_o), 32'h0);
	endtask

	task t_idle;
		wr(irq_unit_pkg::OFS_ENABLE_LOW, 32'h82);
		prio(1, 3'h3);
		wr(irq_unit_pkg::OFS_PERIPH_KEEP, 32'h5);
		wr(irq_unit_pkg::OFS_POWER_CTRL, 32'h1);
		tick(3);
		chk(32'(core_clk_en_o), 32'h0);
		chk(32'(periph_clk_en_o), 32'h5);
		raise(17'h2);
		expect_take(16'h0084, 4'hb);
		chk(32'(core_clk_en_o), 32'h1);
		rd_chk(irq_unit_pkg::OFS_STATUS, 32'h2);
	endtask

	initial
	begin
		do_reset(3'h1);
		t_reset_vals;
		t_cause;
		t_vectors;
		t_gating;
		t_ties;
		t_exc;
		t_power;
		t_idle;
		stop_test;
	end
endmodule
